// [rtl/tdmsw_mode_ctrl.sv]
// Mode, soft reset, block fill and output clock control for a TDM switch.
// Assumes an APB master on pclk; connection memory and PLL sit outside.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module tdmsw_mode_ctrl #(
   parameter int FRAME_CYCLES = tdmsw_pkg::FRAME_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Connection memory fill port
   output logic cm_wr,
   output logic [tdmsw_pkg::CM_AW-1:0] cm_addr,
   output logic [15:0] cm_low,
   output logic [15:0] cm_high,
   // Section resets
   output logic switch_rst,
   output logic pll_rst,
   // Error test engines
   input wire logic [31:0] ber_tx_req,
   input wire logic [31:0] ber_rx_req,
   output logic [31:0] ber_tx_enable,
   output logic [31:0] ber_rx_enable,
   // Stream direction
   output logic [31:0] stream_tie_low,
   output logic [31:0] stream_bidir,
   output logic stream_pulldown_enable,
   // Output clocks and frame pulses
   output logic [3:0] pair_ck,
   output logic [3:0] pair_ck_oe_n,
   output logic [3:0] pair_fp,
   output logic [3:0] pair_fp_oe_n,
   output logic clock_output_pin_four,
   output logic clock_output_pin_four_oe_n,
   output logic clock_out5,
   output logic clock_out5_oe_n,
   // Offset frame pulses
   input wire logic [2:0] offset_src,
   output logic [2:0] offset_frame_pulse_pin,
   output logic [2:0] offset_frame_pulse_pin_oe_n
);
   import tdmsw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] idx;
   logic hit;
   logic wr_en;
   logic wr_mode;
   logic [15:0] rd_val;
   logic block_fill_enable;
   logic [1:0] opmode;
   logic slave_pll_enable;
   logic stream_pd;
   logic bidir_high_half;
   logic bidir_low_half;
   logic error_test_rx_global_enable;
   logic error_test_tx_global_enable;
   logic [2:0] block_fill_value;
   logic fill_start;
   logic fill_pend;
   logic switch_soft_reset;
   logic pll_soft_reset;
   logic [8:0] ocen;
   logic [15:0] ocsel;
   tdmsw_fill_e state;
   logic abort;
   logic fill_done;
   logic launch;
   logic [15:0] frame_pos;
   logic ck_avail;
   logic [31:0] o_incr [6];
   logic [4:0] o_fpw [6];
   logic [5:0] o_run;
   logic [5:0] o_en;
   logic [5:0] o_ckinv;
   logic [5:0] o_fpinv;
   logic [5:0] o_fpst;
   logic [5:0] o_ck;
   logic [5:0] o_fp;
   logic [5:0] o_ck_oe_n;
   logic [5:0] o_fp_oe_n;
   logic [15:0] fill_age;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, so pready is high after reset
   assign idx = paddr[9:2];
   assign hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && idx <= IDX_OCSEL;
   assign wr_en = psel && penable && pwrite && pready && hit;
   assign wr_mode = wr_en && idx == IDX_MODE;

   always_comb begin
      unique case (idx)
         IDX_CTRL: rd_val = 16'((32'(slave_pll_enable) << CTRL_SLV_PLL) |
                               (32'(opmode) << CTRL_OPM_LO) |
                               (32'(block_fill_enable) << CTRL_FILL_EN));
         IDX_MODE: rd_val = {7'h00, stream_pd, bidir_high_half, bidir_low_half,
                             error_test_rx_global_enable, error_test_tx_global_enable,
                             block_fill_value, fill_start};
         IDX_SRST: rd_val = {14'h0000, switch_soft_reset, pll_soft_reset};
         IDX_OCEN: rd_val = {7'h00, ocen};
         IDX_OCSEL: rd_val = ocsel;
         default: rd_val = 16'h0000;
      endcase
   end

   // Read data and error are set up in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            prdata <= hit ? {16'h0000, rd_val} : 32'h0000_0000;
            pslverr <= !hit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_fill_enable <= RST_REG[CTRL_FILL_EN];
         opmode <= RST_REG[CTRL_OPM_LO +: 2];
         slave_pll_enable <= RST_REG[CTRL_SLV_PLL];
      end else if (wr_en && idx == IDX_CTRL) begin
         block_fill_enable <= pwdata[CTRL_FILL_EN];
         opmode <= pwdata[CTRL_OPM_LO +: 2];
         slave_pll_enable <= pwdata[CTRL_SLV_PLL];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stream_pd <= RST_REG[MODE_PD_EN];
         bidir_high_half <= RST_REG[MODE_BD_HI];
         bidir_low_half <= RST_REG[MODE_BD_LO];
         error_test_rx_global_enable <= RST_REG[MODE_RX_EN];
         error_test_tx_global_enable <= RST_REG[MODE_TX_EN];
         block_fill_value <= RST_REG[MODE_VAL_LO +: 3];
      end else if (wr_mode) begin
         stream_pd <= pwdata[MODE_PD_EN];
         bidir_high_half <= pwdata[MODE_BD_HI];
         bidir_low_half <= pwdata[MODE_BD_LO];
         error_test_rx_global_enable <= pwdata[MODE_RX_EN];
         error_test_tx_global_enable <= pwdata[MODE_TX_EN];
         block_fill_value <= pwdata[MODE_VAL_LO +: 3];
      end
   end

   // R8 self clear; a host write in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_start <= RST_REG[MODE_START];
      end else if (wr_mode) begin
         fill_start <= pwdata[MODE_START];
      end else if (fill_done) begin
         fill_start <= 1'b0;
      end
   end

   // R5 rising edge only; rewriting a one does not restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_pend <= 1'b0;
      end else if (wr_mode && pwdata[MODE_START] && !fill_start) begin
         fill_pend <= 1'b1;
      end else if (launch || !fill_start) begin
         fill_pend <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_soft_reset <= RST_REG[SRST_SW];
         pll_soft_reset <= RST_REG[SRST_PLL];
      end else if (wr_en && idx == IDX_SRST) begin
         switch_soft_reset <= pwdata[SRST_SW];
         pll_soft_reset <= pwdata[SRST_PLL];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ocen <= RST_REG[8:0];
         ocsel <= RST_REG;
      end else if (wr_en && idx == IDX_OCEN) begin
         ocen <= pwdata[8:0];
      end else if (wr_en && idx == IDX_OCSEL) begin
         ocsel <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // R9 abort on start or enable low; soft reset also stops the fill
   assign abort = !fill_start || !block_fill_enable || switch_soft_reset;
   assign launch = state == FILL_IDLE && fill_pend && !abort;
   assign fill_done = state == FILL_RUN && !abort && cm_addr == CM_LAST;

   // R7 one entry per cycle, well inside two frames
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FILL_IDLE;
         cm_wr <= 1'b0;
         cm_addr <= '0;
         cm_low <= 16'h0000;
         cm_high <= 16'h0000;
      end else begin
         unique case (state)
            FILL_IDLE: begin
               if (launch) begin
                  state <= FILL_RUN;
                  cm_wr <= 1'b1;
                  cm_addr <= '0;
                  // R3 value into bits 2 to 0
                  // R4 upper bits and high word zero
                  cm_low <= {13'h0000, block_fill_value};
                  cm_high <= 16'h0000;
               end
            end
            FILL_RUN: begin
               if (abort || cm_addr == CM_LAST) begin
                  state <= FILL_IDLE;
                  cm_wr <= 1'b0;
               end else begin
                  cm_addr <= cm_addr + 1'b1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // R11 switch reset, R12 PLL reset, R2/R20 engine gating, R17 streams
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_rst <= 1'b0;
         pll_rst <= 1'b0;
         ber_tx_enable <= 32'h0000_0000;
         ber_rx_enable <= 32'h0000_0000;
         stream_tie_low <= 32'h0000_0000;
         stream_bidir <= 32'h0000_0000;
         stream_pulldown_enable <= 1'b0;
         offset_frame_pulse_pin <= 3'h0;
         offset_frame_pulse_pin_oe_n <= 3'h7;
      end else begin
         switch_rst <= switch_soft_reset;
         pll_rst <= pll_soft_reset;
         ber_tx_enable <= ber_tx_req & {32{error_test_tx_global_enable}};
         ber_rx_enable <= ber_rx_req & {32{error_test_rx_global_enable}};
         stream_tie_low <= {{16{bidir_high_half}}, {16{bidir_low_half}}};
         stream_bidir <= {{16{bidir_high_half}}, {16{bidir_low_half}}};
         stream_pulldown_enable <= stream_pd;
         // R13 offset pulse drive
         offset_frame_pulse_pin <= offset_src;
         offset_frame_pulse_pin_oe_n <= ~ocen[OCEN_OFS_LO +: 3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_pos <= 16'h0000;
      end else if (frame_pos == 16'(FRAME_CYCLES - 1)) begin
         frame_pos <= 16'h0000;
      end else begin
         frame_pos <= frame_pos + 16'h0001;
      end
   end

   // R15 master or slave with PLL
   assign ck_avail = opmode == OPM_MASTER || slave_pll_enable;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // R18 pair three rate select
         o_incr[i] = PAIR_INC[i == 3 ? ocsel[OCSEL_P3SEL +: 2] : PAIR_SEL_FIXED];
         o_fpw[i] = PAIR_FPW[i == 3 ? ocsel[OCSEL_P3SEL +: 2] : PAIR_SEL_FIXED];
         o_run[i] = 1'b1;
         // R16 pair enable
         o_en[i] = ocen[i];
         o_ckinv[i] = ocsel[3 * i + 2];
         o_fpinv[i] = ocsel[3 * i + 1];
         o_fpst[i] = ocsel[3 * i];
      end
      o_incr[4] = ocsel[OCSEL_CK4SEL] ? INC_1M544 : INC_2M048;
      o_incr[5] = INC_CK5;
      o_fpw[4] = PAIR_FPW[0];
      o_fpw[5] = PAIR_FPW[0];
      o_run[5:4] = {2{ck_avail}};
      // R14 fifth clock enable
      o_en[5:4] = {ocen[OCEN_CK5], ocen[OCEN_CK4]};
      o_ckinv[5:4] = {1'b0, ocsel[OCSEL_CK4P]};
      o_fpinv[5:4] = 2'h0;
      o_fpst[5:4] = 2'h0;
   end

   for (genvar g = 0; g < 6; g++) begin : g_out
      tdmsw_outgen u_out (
         .pclk(pclk),
         .presetn(presetn),
         .frame_pos(frame_pos),
         .frame_len(16'(FRAME_CYCLES)),
         .incr(o_incr[g]),
         .fp_width(o_fpw[g]),
         .run(o_run[g]),
         .enable(o_en[g]),
         .ck_inv(o_ckinv[g]),
         .fp_inv(o_fpinv[g]),
         .fp_start(o_fpst[g]),
         .ck(o_ck[g]),
         .fp(o_fp[g]),
         .ck_oe_n(o_ck_oe_n[g]),
         .fp_oe_n(o_fp_oe_n[g])
      );
   end

   assign pair_ck = o_ck[3:0];
   assign pair_fp = o_fp[3:0];
   assign pair_ck_oe_n = o_ck_oe_n[3:0];
   assign pair_fp_oe_n = o_fp_oe_n[3:0];
   assign clock_output_pin_four = o_ck[4];
   assign clock_output_pin_four_oe_n = o_ck_oe_n[4];
   assign clock_out5 = o_ck[5];
   assign clock_out5_oe_n = o_ck_oe_n[5];

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_age <= 16'h0000;
      end else begin
         fill_age <= state == FILL_RUN ? fill_age + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_tx_gate;
      (|ber_tx_enable) |-> $past(error_test_tx_global_enable);
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("tx enabled while gated"); // R2
   property p_fill_low;
      cm_wr |-> cm_low[2:0] == block_fill_value;
   endproperty
   a_fill_low: assert property (p_fill_low) else $error("fill value wrong"); // R3
   property p_fill_zero;
      cm_wr |-> cm_low[15:3] == 13'h0000 && cm_high == 16'h0000;
   endproperty
   a_fill_zero: assert property (p_fill_zero) else $error("fill bits not zero"); // R4
   property p_launch;
      launch |=> cm_wr && cm_addr == '0 ##1 cm_wr || $past(abort);
   endproperty
   a_launch: assert property (p_launch) else $error("fill did not start"); // R5
   property p_two_frames;
      int'(fill_age) <= 2 * FRAME_CYCLES;
   endproperty
   a_two_frames: assert property (p_two_frames) else $error("fill too long"); // R7
   property p_self_clear;
      fill_done && !wr_mode |=> !fill_start && state == FILL_IDLE;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("start not cleared"); // R8
   property p_abort;
      state == FILL_RUN && !block_fill_enable |=> !cm_wr [*2];
   endproperty
   a_abort: assert property (p_abort) else $error("abort ignored"); // R9
   property p_sw_rst;
      switch_rst == $past(switch_soft_reset);
   endproperty
   a_sw_rst: assert property (p_sw_rst) else $error("switch reset not held"); // R11
   property p_pll_rst;
      pll_rst == $past(pll_soft_reset);
   endproperty
   a_pll_rst: assert property (p_pll_rst) else $error("pll reset wrong"); // R12
   property p_ofs_oe;
      ##1 offset_frame_pulse_pin_oe_n == ~$past(ocen[OCEN_OFS_LO +: 3]);
   endproperty
   a_ofs_oe: assert property (p_ofs_oe) else $error("offset pulse drive wrong"); // R13
   property p_ck5_avail;
      !ck_avail |=> ##1 clock_out5 == 1'b0;
   endproperty
   a_ck5_avail: assert property (p_ck5_avail) else $error("clock five ran"); // R15
   property p_pair_oe;
      ##1 pair_ck_oe_n == pair_fp_oe_n && pair_ck_oe_n == ~$past(ocen[3:0]);
   endproperty
   a_pair_oe: assert property (p_pair_oe) else $error("pair drive wrong"); // R16
   property p_rx_gate;
      (|ber_rx_enable) |-> $past(error_test_rx_global_enable);
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("rx enabled while gated"); // R20
   c_fill_done: cover property (fill_done);
   c_fill_abort: cover property (state == FILL_RUN && abort);
   c_pair_on: cover property (pair_ck_oe_n == 4'h0);
   c_ck5_on: cover property (!clock_out5_oe_n && ck_avail);
endmodule

// [shared/tdmsw_pkg.sv]
// Constants for the TDM switch mode and output control block.
// Assumes a 50 MHz APB clock and a 125 us frame.
// Overview of operation
// R1 - Software writes zero to unused reserved bits of the reset control register.
// R2 - Transmit global enable low keeps every error test transmitter disabled.
// R3 - Block fill loads the three-bit value into low word bits 2 to 0.
// R4 - Block fill clears low word bits 15 to 3 and whole high word.
// R5 - A zero-to-one write of the start bit launches block fill.
// R6 - Host writes start bit and fill value in one single write.
// R7 - Block fill completes within two frames once enabled and started.
// R8 - Device clears the start bit itself when block fill ends.
// R9 - Clearing start bit or fill enable while running aborts the fill.
// R10 - While start is high, host rewrites other mode bits unchanged.
// R11 - Switch soft reset bit high holds switching blocks in reset.
// R12 - PLL soft reset bit high holds the PLL section in reset.
// R13 - Each offset frame pulse pin is driven only while enabled.
// R14 - Fifth output clock driven while enabled, high impedance otherwise.
// R15 - Fifth output clock runs only in master mode or with slave PLL.
// R16 - Each clock and frame pulse pair is driven or released together.
// R17 - Bidirectional bits tie stream inputs low and make stream pins bidirectional.
// R18 - Pair three select picks 4.096 to 32.768 MHz with matching pulse widths.
// R19 - Polarity and position bits invert outputs and pick straddle or start.
// R20 - Receive global enable low keeps every error test receiver disabled.
package tdmsw_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_MODE = 8'h01;
   localparam logic [7:0] IDX_SRST = 8'h02;
   localparam logic [7:0] IDX_OCEN = 8'h03;
   localparam logic [7:0] IDX_OCSEL = 8'h04;
   localparam logic [15:0] RST_REG = 16'h0000;
   // Control register fields
   localparam int CTRL_FILL_EN = 3;
   localparam int CTRL_OPM_LO = 11;
   localparam int CTRL_SLV_PLL = 13;
   localparam logic [1:0] OPM_MASTER = 2'h0;
   // Mode register fields
   localparam int MODE_START = 0;
   localparam int MODE_VAL_LO = 1;
   localparam int MODE_TX_EN = 4;
   localparam int MODE_RX_EN = 5;
   localparam int MODE_BD_LO = 6;
   localparam int MODE_BD_HI = 7;
   localparam int MODE_PD_EN = 8;
   // Soft reset fields
   localparam int SRST_PLL = 0;
   localparam int SRST_SW = 1;
   // Output enable fields
   localparam int OCEN_CK4 = 4;
   localparam int OCEN_CK5 = 5;
   localparam int OCEN_OFS_LO = 6;
   // Output select fields
   localparam int OCSEL_P3SEL = 12;
   localparam int OCSEL_CK4SEL = 14;
   localparam int OCSEL_CK4P = 15;
   localparam logic [1:0] PAIR_SEL_FIXED = 2'h0;
   // Connection memory
   localparam int CM_AW = 11;
   localparam logic [10:0] CM_LAST = 11'h7FF;
   // Timing
   localparam int CLK_NS = 20;
   localparam longint CLK_HZ = 50000000;
   localparam int FRAME_NS = 125000;
   localparam int FRAME_CYC = FRAME_NS / CLK_NS;
   localparam int FP_NS [4] = '{244, 122, 61, 30};
   localparam logic [4:0] PAIR_FPW [4] = '{
      5'((FP_NS[0] + CLK_NS - 1) / CLK_NS), 5'((FP_NS[1] + CLK_NS - 1) / CLK_NS),
      5'((FP_NS[2] + CLK_NS - 1) / CLK_NS), 5'((FP_NS[3] + CLK_NS - 1) / CLK_NS)};
   // Phase increments: rate * 2^32 / clock
   localparam logic [31:0] PAIR_INC [4] = '{
      32'((64'd4096000 << 32) / CLK_HZ), 32'((64'd8192000 << 32) / CLK_HZ),
      32'((64'd16384000 << 32) / CLK_HZ), 32'((64'd32768000 << 32) / CLK_HZ)};
   localparam logic [31:0] INC_2M048 = 32'((64'd2048000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_1M544 = 32'((64'd1544000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_CK5 = 32'((64'd8192000 << 32) / CLK_HZ);
   typedef enum logic {FILL_IDLE = 1'b0, FILL_RUN = 1'b1} tdmsw_fill_e;
endpackage

// [rtl/tdmsw_outgen.sv]
// One output clock and frame pulse generator.
// Assumes a frame position counter from the parent on the same clock.
`timescale 1ns/1ns
module tdmsw_outgen (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Timing
   input wire logic [15:0] frame_pos,
   input wire logic [15:0] frame_len,
   input wire logic [31:0] incr,
   input wire logic [4:0] fp_width,
   // Control
   input wire logic run,
   input wire logic enable,
   input wire logic ck_inv,
   input wire logic fp_inv,
   input wire logic fp_start,
   // Pins
   output logic ck,
   output logic fp,
   output logic ck_oe_n,
   output logic fp_oe_n
);
   import tdmsw_pkg::*;
   logic [31:0] acc;
   logic [15:0] half;
   logic [15:0] lead;
   logic fp_act;

   // R19 straddle or start
   always_comb begin
      half = 16'(fp_width >> 1);
      lead = 16'(fp_width) - half;
      if (fp_start) begin
         fp_act = frame_pos < 16'(fp_width);
      end else begin
         fp_act = (frame_pos < lead) || (frame_pos >= frame_len - half);
      end
   end

   // Phase restarts each frame so the clock stays frame aligned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (!run || frame_pos == 16'h0000) begin
         acc <= '0;
      end else begin
         acc <= acc + incr;
      end
   end

   // R19 polarity inversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck <= 1'b0;
         fp <= 1'b1;
         ck_oe_n <= 1'b1;
         fp_oe_n <= 1'b1;
      end else begin
         ck <= (acc[31] & run) ^ ck_inv;
         fp <= (fp_act & run) ^ ~fp_inv;
         ck_oe_n <= ~enable;
         fp_oe_n <= ~enable;
      end
   end
endmodule

// [tb/tdmsw_host.sv]
// Host processor model: APB master for the mode control block.
// Assumes callers enter xfer just after a rising pclk edge.
`timescale 1ns/1ns
module tdmsw_host (
   // Clock
   input wire logic pclk,
   // Slave answer
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Request
   output logic [11:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata
);
   initial begin
      paddr = 12'h000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
         output logic [31:0] rd, output logic err);
      paddr <= {2'b00, idx, 2'b00};
      pwrite <= wr;
      pwdata <= {16'h0000, wd};
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // Released lines must not keep the last value
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      @(posedge pclk);
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the mode and output control block.
// Assumes the host model drives APB; frame shortened by FRAME_CYCLES.
`timescale 1ns/1ns
module testbench;
   import tdmsw_pkg::*;
   localparam int FC = 1100;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr;
   logic psel, penable, pwrite, pready, pslverr, cm_wr, switch_rst, pll_rst;
   logic [31:0] pwdata, prdata, ber_tx_req, ber_rx_req, ber_tx_enable, ber_rx_enable;
   logic [31:0] stream_tie_low, stream_bidir, rd;
   logic [10:0] cm_addr;
   logic [15:0] cm_low, cm_high;
   logic [3:0] pair_ck, pair_ck_oe_n, pair_fp, pair_fp_oe_n;
   logic stream_pulldown_enable, clock_output_pin_four, clock_output_pin_four_oe_n;
   logic clock_out5, clock_out5_oe_n, err;
   logic [2:0] offset_src, offset_frame_pulse_pin, offset_frame_pulse_pin_oe_n;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n, t, bad, p;
   tdmsw_host i_host (.pclk, .pready, .pslverr, .prdata, .paddr, .psel, .penable,
      .pwrite, .pwdata);
   tdmsw_mode_ctrl #(.FRAME_CYCLES(FC)) i_dut (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .cm_wr, .cm_addr, .cm_low, .cm_high,
      .switch_rst, .pll_rst, .ber_tx_req, .ber_rx_req, .ber_tx_enable, .ber_rx_enable,
      .stream_tie_low, .stream_bidir, .stream_pulldown_enable, .pair_ck, .pair_ck_oe_n,
      .pair_fp, .pair_fp_oe_n, .clock_output_pin_four, .clock_output_pin_four_oe_n,
      .clock_out5, .clock_out5_oe_n, .offset_src, .offset_frame_pulse_pin,
      .offset_frame_pulse_pin_oe_n);
   always #10 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard, well above the fill length
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [15:0] d);
      @(posedge pclk);
      i_host.xfer(1'b1, i, d, rd, err);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [15:0] e);
      @(posedge pclk);
      i_host.xfer(1'b0, i, 16'h0000, rd, err);
      chk(rd, {16'h0000, e});
   endtask
   task automatic settle;
      repeat (3) @(negedge pclk);
   endtask
   task automatic wait_fill;
      t = 0;
      do begin
         @(negedge pclk);
         t++;
      end while (cm_wr !== 1'b1 && t < 20);
      chk(32'(t < 20), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      for (int i = 0; i < 5; i++) rdc(8'(i), 16'h0000);
      @(posedge pclk);
      i_host.xfer(1'b0, 8'h05, 16'h0000, rd, err);
      chk({31'h0, err}, 32'h1);
      wr(IDX_OCSEL, 16'hFFFF);
      rdc(IDX_OCSEL, 16'hFFFF);
      for (int v = 3; v >= 0; v--) begin
         wr(IDX_SRST, 16'(v));
         settle;
         chk({30'h0, switch_rst, pll_rst}, 32'(v));
      end
   endtask
   task automatic t_mode;
      logic [15:0] m;
      for (int i = 4; i < 9; i++) begin
         m = 16'h0001 << i;
         wr(IDX_MODE, m);
         settle;
         chk(ber_tx_enable, m[MODE_TX_EN] ? ber_tx_req : 32'h0000_0000);
         chk(ber_rx_enable, m[MODE_RX_EN] ? ber_rx_req : 32'h0000_0000);
         chk(stream_tie_low, {{16{m[MODE_BD_HI]}}, {16{m[MODE_BD_LO]}}});
         chk(stream_bidir, {{16{m[MODE_BD_HI]}}, {16{m[MODE_BD_LO]}}});
         chk({31'h0, stream_pulldown_enable}, {31'h0, m[MODE_PD_EN]});
      end
   endtask
   task automatic t_oe;
      logic [15:0] ov [3] = '{16'h01FF, 16'h00A5, 16'h0000};
      foreach (ov[k]) begin
         wr(IDX_OCEN, ov[k]);
         settle;
         chk({28'h0, pair_ck_oe_n}, {28'h0, ~ov[k][3:0]});
         chk({28'h0, pair_fp_oe_n}, {28'h0, ~ov[k][3:0]});
         chk({30'h0, clock_out5_oe_n, clock_output_pin_four_oe_n}, {30'h0, ~ov[k][5:4]});
         chk({29'h0, offset_frame_pulse_pin_oe_n}, {29'h0, ~ov[k][8:6]});
      end
      chk({29'h0, offset_frame_pulse_pin}, 32'h5);
      wr(IDX_OCEN, 16'h0030);
      // Slave without PLL first, then with it
      for (int k = 0; k < 2; k++) begin
         wr(IDX_CTRL, k ? 16'h2800 : 16'h0800);
         settle;
         n = 0;
         t = 0;
         p = 0;
         bad = 0;
         repeat (FC) @(negedge pclk) begin
            n += (clock_out5 === 1'b1);
            t += (clock_output_pin_four === 1'b0);
            p += (pair_ck[0] === 1'b0);
            bad += (pair_fp[0] === 1'b1);
         end
         chk(32'(n > 0), 32'(k));
         chk(32'(t > 0), 32'(k));
         chk(32'(p > 0), 32'h1);
         chk(32'(bad), 32'(PAIR_FPW[0]));
      end
      wr(IDX_CTRL, 16'h0000);
   endtask
   task automatic t_fill;
      wr(IDX_CTRL, 16'h0008);
      wr(IDX_MODE, 16'h001B);
      wait_fill;
      n = 0;
      bad = 0;
      while (cm_wr === 1'b1) begin
         if (cm_addr !== 11'(n) || cm_low !== 16'h0005 || cm_high !== 16'h0000) bad++;
         n++;
         @(negedge pclk);
      end
      chk(32'(n), 32'd2048);
      chk(32'(bad), 32'h0);
      chk(32'(n + t <= 2 * FC), 32'h1);
      rdc(IDX_MODE, 16'h001A);
      // Abort by fill enable, then by start bit
      for (int k = 0; k < 2; k++) begin
         wr(IDX_MODE, 16'h0006);
         wr(IDX_CTRL, 16'h0008);
         wr(IDX_MODE, 16'h0007);
         wait_fill;
         if (k == 0) wr(IDX_CTRL, 16'h0000);
         else wr(IDX_MODE, 16'h0006);
         settle;
         n = 0;
         repeat (20) @(negedge pclk) n += (cm_wr !== 1'b0);
         chk(32'(n), 32'h0);
      end
   endtask
   initial begin
      ber_tx_req = 32'hFFFF_0F0F;
      ber_rx_req = 32'h1234_5678;
      offset_src = 3'b101;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_mode;
      t_oe;
      t_fill;
      stop_test();
   end
endmodule
